// ### design/core_sfr_pkg.sv
package core_sfr_pkg;

  // Direct special-register addresses
  localparam logic [7:0] ADDR_STACK_POINTER_LOW   = 8'h81;
  localparam logic [7:0] ADDR_POINTER_LOW_BYTE    = 8'h82;
  localparam logic [7:0] ADDR_POINTER_HIGH_BYTE   = 8'h83;
  localparam logic [7:0] ADDR_POINTER_PAGE_BYTE   = 8'h84;
  localparam logic [7:0] ADDR_POWER_CONTROL       = 8'h87;
  localparam logic [7:0] ADDR_CORE_CONFIGURATION  = 8'haf;
  localparam logic [7:0] ADDR_STACK_POINTER_HIGH  = 8'hb7;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;

  // Values after reset
  localparam logic [7:0] RESET_POINTER_BYTE        = 8'h00;
  localparam logic [7:0] RESET_STACK_POINTER_LOW   = 8'h07;
  localparam logic [2:0] RESET_STACK_POINTER_HIGH  = 3'h0;
  localparam logic [7:0] RESET_PROGRAM_STATUS_WORD = 8'h00;
  localparam logic [7:0] RESET_POWER_CONTROL       = 8'h00;
  localparam logic [7:0] RESET_CORE_CONFIGURATION  = 8'h00;

  // Power control fields
  localparam int PC_BAUD_DOUBLER   = 7;
  localparam int PC_SERIAL_WAKE    = 6;
  localparam int PC_EXT_IRQ_WAKE   = 5;
  localparam int PC_LATCH_DISABLE  = 4;
  localparam int PC_SPARE_ONE      = 3;
  localparam int PC_SPARE_ZERO     = 2;
  localparam int PC_POWERDOWN      = 1;

  // Core configuration fields
  localparam int CFG_EXT_STACK     = 7;
  localparam int CFG_ONCHIP_XDATA  = 0;

  // Status word fields
  localparam int SW_CARRY          = 7;
  localparam int SW_AUX_CARRY      = 6;
  localparam int SW_USER_A         = 5;
  localparam int SW_BANK_HIGH      = 4;
  localparam int SW_BANK_LOW       = 3;
  localparam int SW_OVERFLOW       = 2;
  localparam int SW_USER_B         = 1;
  localparam int SW_PARITY         = 0;

  // Last pointer value that still hits the on-chip data RAM
  localparam logic [23:0] ONCHIP_XDATA_LAST = 24'h0007ff;

  typedef enum logic {
    POWER_RUN  = 1'b0,
    POWER_DOWN = 1'b1
  } power_state_e;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_synced
);

  typedef struct packed {
    logic first;
    logic second;
  } sync_s;

  sync_s q;
  sync_s d;

  // Two-stage chain, idle level high
  always_comb begin
    d        = q;
    d.first  = pin_in;
    d.second = q.first;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= '{first: 1'b1, second: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign pin_synced = q.second;

endmodule
`default_nettype wire

// ### design/stack_pointer_unit.sv
`timescale 1ns/100ps
`default_nettype none
module stack_pointer_unit
  import core_sfr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        load_low,
  input  wire logic        load_high,
  input  wire logic [7:0]  wdata,
  input  wire logic        ext_enable,
  output logic      [7:0]  low_value,
  output logic      [2:0]  high_value,
  output logic      [10:0] top_address
);

  typedef struct packed {
    logic [7:0]  low;
    logic [2:0]  high;
    logic [10:0] top;
  } stack_s;

  stack_s      q;
  stack_s      d;
  logic [10:0] full_value;

  // Pre-increment on push, post-decrement on pop; a load wins
  always_comb begin
    d          = q;
    full_value = {q.high, q.low};
    if (push) begin
      if (ext_enable) begin
        {d.high, d.low} = full_value + 11'h001;
      end else begin
        d.low = q.low + 8'h01;
      end
    end else if (pop) begin
      if (ext_enable) begin
        {d.high, d.low} = full_value - 11'h001;
      end else begin
        d.low = q.low - 8'h01;
      end
    end
    if (load_low) begin
      d.low = wdata;
    end
    if (load_high) begin
      d.high = wdata[2:0];
    end
    d.top = ext_enable ? {d.high, d.low} : {3'h0, d.low};
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= '{low: RESET_STACK_POINTER_LOW, high: RESET_STACK_POINTER_HIGH,
             top: {3'h0, RESET_STACK_POINTER_LOW}};
    end else begin
      q <= d;
    end
  end

  assign low_value   = q.low;
  assign high_value  = q.high;
  assign top_address = q.top;

endmodule
`default_nettype wire

// ### design/core_special_registers.sv
`timescale 1ns/100ps
`default_nettype none
module core_special_registers
  import core_sfr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        pointer_increment,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic        status_update,
  input  wire logic [7:0]  status_flags_in,
  input  wire logic        acc_parity,
  input  wire logic        serial_irq,
  input  wire logic        external_interrupt_zero,
  input  wire logic        ext_irq_edge_select,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_read_hit,
  output logic      [23:0] data_pointer,
  output logic      [10:0] stack_top_address,
  output logic      [1:0]  bank_select,
  output logic      [7:0]  program_status_word,
  output logic             baud_doubler,
  output logic             latch_strobe_enable,
  output logic             powerdown_active,
  output logic             extended_stack_enable,
  output logic             onchip_xdata_select
);

  typedef struct packed {
    logic [7:0]   page_byte;
    logic [7:0]   high_byte;
    logic [7:0]   low_byte;
    logic [7:0]   status;
    logic [7:2]   power_bits;
    power_state_e power;
    logic         ext_stack;
    logic         xdata_map;
    logic [7:0]   rdata;
    logic         rd_hit;
    logic         int_zero_prev;
    logic         latch_on;
    logic         xdata_onchip;
  } regs_s;

  localparam regs_s RESET_STATE = '{
    page_byte:     RESET_POINTER_BYTE,
    high_byte:     RESET_POINTER_BYTE,
    low_byte:      RESET_POINTER_BYTE,
    status:        RESET_PROGRAM_STATUS_WORD,
    power_bits:    RESET_POWER_CONTROL[7:2],
    power:         POWER_RUN,
    ext_stack:     RESET_CORE_CONFIGURATION[CFG_EXT_STACK],
    xdata_map:     RESET_CORE_CONFIGURATION[CFG_ONCHIP_XDATA],
    rdata:         8'h00,
    rd_hit:        1'b0,
    int_zero_prev: 1'b1,
    latch_on:      1'b1,
    xdata_onchip:  1'b0
  };

  regs_s       q;
  regs_s       d;
  logic        int_zero_synced;
  logic        wake_serial;
  logic        wake_ext;
  logic        wr_stack_low;
  logic        wr_stack_high;
  logic [7:0]  stack_low;
  logic [2:0]  stack_high;
  logic [23:0] next_pointer;

  // External interrupt pin enters the clock domain
  pin_sync u_int_zero_sync (
    .clock      (clock),
    .reset_n    (reset_n),
    .pin_in     (external_interrupt_zero),
    .pin_synced (int_zero_synced)
  );

  // Stack writes; the high byte only while extension is on
  assign wr_stack_low  = sfr_wr && (sfr_addr == ADDR_STACK_POINTER_LOW);
  assign wr_stack_high = sfr_wr && (sfr_addr == ADDR_STACK_POINTER_HIGH)
                         && q.ext_stack;

  stack_pointer_unit u_stack (
    .clock       (clock),
    .reset_n     (reset_n),
    .push        (stack_push),
    .pop         (stack_pop),
    .load_low    (wr_stack_low),
    .load_high   (wr_stack_high),
    .wdata       (sfr_wdata),
    .ext_enable  (q.ext_stack),
    .low_value   (stack_low),
    .high_value  (stack_high),
    .top_address (stack_top_address)
  );

  // Wake sources for power-down
  assign wake_serial = q.power_bits[PC_SERIAL_WAKE] && serial_irq;
  assign wake_ext    = q.power_bits[PC_EXT_IRQ_WAKE]
                       && (ext_irq_edge_select
                           ? (q.int_zero_prev && !int_zero_synced)
                           : !int_zero_synced);

  // Next state of every register
  always_comb begin
    d            = q;
    next_pointer = {q.page_byte, q.high_byte, q.low_byte};
    if (pointer_increment) begin
      next_pointer = next_pointer + 24'h000001;
    end
    {d.page_byte, d.high_byte, d.low_byte} = next_pointer;
    if (status_update) begin
      d.status[7:1] = status_flags_in[7:1];
    end
    d.status[SW_PARITY] = acc_parity;
    if ((q.power == POWER_DOWN) && (wake_serial || wake_ext)) begin
      d.power = POWER_RUN;
    end
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_POINTER_LOW_BYTE:    d.low_byte  = sfr_wdata;
        ADDR_POINTER_HIGH_BYTE:   d.high_byte = sfr_wdata;
        ADDR_POINTER_PAGE_BYTE:   d.page_byte = sfr_wdata;
        ADDR_PROGRAM_STATUS_WORD: d.status[7:1] = sfr_wdata[7:1];
        ADDR_POWER_CONTROL: begin
          d.power_bits = sfr_wdata[7:2];
          if (sfr_wdata[PC_POWERDOWN]) begin
            d.power = POWER_DOWN;
          end
        end
        ADDR_CORE_CONFIGURATION: begin
          d.ext_stack = sfr_wdata[CFG_EXT_STACK];
          d.xdata_map = sfr_wdata[CFG_ONCHIP_XDATA];
        end
        default: begin
        end
      endcase
    end
    if (sfr_rd) begin
      d.rd_hit = 1'b1;
      case (sfr_addr)
        ADDR_POINTER_LOW_BYTE:    d.rdata = q.low_byte;
        ADDR_POINTER_HIGH_BYTE:   d.rdata = q.high_byte;
        ADDR_POINTER_PAGE_BYTE:   d.rdata = q.page_byte;
        ADDR_STACK_POINTER_LOW:   d.rdata = stack_low;
        ADDR_PROGRAM_STATUS_WORD: d.rdata = q.status;
        ADDR_POWER_CONTROL:
          d.rdata = {q.power_bits, q.power == POWER_DOWN, 1'b0};
        ADDR_CORE_CONFIGURATION:
          d.rdata = {q.ext_stack, 6'h00, q.xdata_map};
        ADDR_STACK_POINTER_HIGH: begin
          d.rd_hit = q.ext_stack;
          d.rdata  = q.ext_stack ? {5'h00, stack_high} : 8'h00;
        end
        default: begin
          d.rd_hit = 1'b0;
          d.rdata  = 8'h00;
        end
      endcase
    end
    d.int_zero_prev = int_zero_synced;
    d.latch_on      = !d.power_bits[PC_LATCH_DISABLE];
    d.xdata_onchip  = d.xdata_map
                      && ({d.page_byte, d.high_byte, d.low_byte}
                          <= ONCHIP_XDATA_LAST);
  end

  // State register
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  assign sfr_rdata             = q.rdata;
  assign sfr_read_hit          = q.rd_hit;
  assign data_pointer          = {q.page_byte, q.high_byte, q.low_byte};
  assign bank_select           = q.status[SW_BANK_HIGH:SW_BANK_LOW];
  assign program_status_word   = q.status;
  assign baud_doubler          = q.power_bits[PC_BAUD_DOUBLER];
  assign latch_strobe_enable   = q.latch_on;
  assign powerdown_active      = (q.power == POWER_DOWN);
  assign extended_stack_enable = q.ext_stack;
  assign onchip_xdata_select   = q.xdata_onchip;

  // Checks on the register behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic quiet_wr;
  assign quiet_wr = !sfr_wr;

  property p_pointer_carry;
    pointer_increment && quiet_wr
      |=> data_pointer == $past(data_pointer) + 24'h000001;
  endproperty
  a_pointer_carry: assert property (p_pointer_carry)
    else $error("pointer increment lost its carry");

  property p_byte_write;
    sfr_wr && (sfr_addr == ADDR_POINTER_HIGH_BYTE)
      |=> data_pointer[15:8] == $past(sfr_wdata)
          && data_pointer[23:16] == $past(data_pointer[23:16], 1)
             + {7'h00, $past(pointer_increment) && ($past(data_pointer[15:0]) == 16'hffff)};
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("pointer high byte write failed");

  property p_push_then_top;
    stack_push && quiet_wr && !q.ext_stack
      |=> stack_top_address == {3'h0, $past(stack_low) + 8'h01};
  endproperty
  a_push_then_top: assert property (p_push_then_top)
    else $error("push did not pre-increment the stack");

  property p_stack_reset;
    !$past(reset_n) |-> stack_low == RESET_STACK_POINTER_LOW && !extended_stack_enable;
  endproperty
  a_stack_reset: assert property (p_stack_reset)
    else $error("stack pointer not 07 after reset");

  property p_ext_rollover;
    stack_push && quiet_wr && q.ext_stack && stack_top_address == 11'h0ff
      |=> stack_top_address == 11'h100 && stack_high == 3'h1;
  endproperty
  a_ext_rollover: assert property (p_ext_rollover)
    else $error("extended stack did not roll into 0100");

  property p_high_hidden;
    sfr_rd && sfr_addr == ADDR_STACK_POINTER_HIGH && !q.ext_stack
      |=> sfr_rdata == 8'h00 && !sfr_read_hit;
  endproperty
  a_high_hidden: assert property (p_high_hidden)
    else $error("stack high readable while disabled");

  property p_powerdown_entry;
    sfr_wr && sfr_addr == ADDR_POWER_CONTROL && sfr_wdata[PC_POWERDOWN]
      |=> powerdown_active;
  endproperty
  a_powerdown_entry: assert property (p_powerdown_entry)
    else $error("power-down not entered");

  property p_serial_wake;
    powerdown_active && wake_serial && !sfr_wr |=> !powerdown_active;
  endproperty
  a_serial_wake: assert property (p_serial_wake)
    else $error("serial interrupt did not wake");

  property p_latch_off;
    sfr_wr && sfr_addr == ADDR_POWER_CONTROL
      |=> latch_strobe_enable == !$past(sfr_wdata[PC_LATCH_DISABLE]);
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("latch strobe enable wrong");

  property p_xdata_window;
    onchip_xdata_select |-> q.xdata_map && data_pointer <= ONCHIP_XDATA_LAST;
  endproperty
  a_xdata_window: assert property (p_xdata_window)
    else $error("on-chip data RAM selected outside its window");

  property p_ext_wake;
    powerdown_active && wake_ext && !sfr_wr |=> !powerdown_active;
  endproperty
  a_ext_wake: assert property (p_ext_wake)
    else $error("external interrupt zero did not wake");

  property p_baud_follow;
    sfr_wr && sfr_addr == ADDR_POWER_CONTROL
      |=> baud_doubler == $past(sfr_wdata[PC_BAUD_DOUBLER]);
  endproperty
  a_baud_follow: assert property (p_baud_follow)
    else $error("baud doubler does not follow power bit 7");

  c_wake_ext: cover property (powerdown_active && wake_ext ##1 !powerdown_active);
  c_rollover: cover property (q.ext_stack && stack_push && stack_top_address == 11'h0ff);
  c_page_carry: cover property (pointer_increment && data_pointer[15:0] == 16'hffff);

endmodule
`default_nettype wire

// ### tb/core_special_registers_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Compare one value, count it, report a mismatch
`define CHECK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module core_special_registers_tb_top
  import core_sfr_pkg::*;
;
  logic        clock;
  logic        reset_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic        pointer_increment;
  logic        stack_push;
  logic        stack_pop;
  logic        status_update;
  logic [7:0]  status_flags_in;
  logic        acc_parity;
  logic        serial_irq;
  logic        external_interrupt_zero;
  logic        ext_irq_edge_select;
  logic [7:0]  sfr_rdata;
  logic        sfr_read_hit;
  logic [23:0] data_pointer;
  logic [10:0] stack_top_address;
  logic [1:0]  bank_select;
  logic [7:0]  program_status_word;
  logic        baud_doubler;
  logic        latch_strobe_enable;
  logic        powerdown_active;
  logic        extended_stack_enable;
  logic        onchip_xdata_select;
  int          fails;
  int          n_compared;

  core_special_registers DUT (
    .clock(clock), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .pointer_increment(pointer_increment),
    .stack_push(stack_push), .stack_pop(stack_pop), .status_update(status_update),
    .status_flags_in(status_flags_in), .acc_parity(acc_parity), .serial_irq(serial_irq),
    .external_interrupt_zero(external_interrupt_zero),
    .ext_irq_edge_select(ext_irq_edge_select), .sfr_rdata(sfr_rdata),
    .sfr_read_hit(sfr_read_hit), .data_pointer(data_pointer),
    .stack_top_address(stack_top_address), .bank_select(bank_select),
    .program_status_word(program_status_word), .baud_doubler(baud_doubler),
    .latch_strobe_enable(latch_strobe_enable), .powerdown_active(powerdown_active),
    .extended_stack_enable(extended_stack_enable),
    .onchip_xdata_select(onchip_xdata_select)
  );

  // 100 MHz clock
  always begin
    #5 clock = ~clock;
  end

  // Register write, visible after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // Register read with expected data and hit flag
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clock);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
    `CHECK(sfr_rdata, e)
    `CHECK(sfr_read_hit, h)
  endtask

  // One-cycle core strobe: 0 increment, 1 push, 2 pop, 3 status load
  task automatic strobe(input int k);
    @(posedge clock);
    pointer_increment <= (k == 0);
    stack_push <= (k == 1);
    stack_pop <= (k == 2);
    status_update <= (k == 3);
    @(posedge clock);
    pointer_increment <= 1'b0;
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    status_update <= 1'b0;
    #1;
  endtask

  // Bounded wait for the end of power-down
  task automatic wait_wake(input int lim);
    int i;
    for (i = 0; i < lim && powerdown_active !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    `CHECK(powerdown_active, 1'b0)
    if (powerdown_active !== 1'b0) begin
      finish_test();
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    pointer_increment = 1'b0;
    stack_push = 1'b0;
    stack_pop = 1'b0;
    status_update = 1'b0;
    status_flags_in = 8'h00;
    acc_parity = 1'b0;
    serial_irq = 1'b0;
    external_interrupt_zero = 1'b1;
    ext_irq_edge_select = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    // Reset values
    `CHECK(stack_top_address, 11'h007)
    `CHECK(latch_strobe_enable, 1'b1)
    `CHECK(extended_stack_enable, 1'b0)
    rd(ADDR_STACK_POINTER_LOW, 8'h07, 1'b1);
    rd(ADDR_CORE_CONFIGURATION, 8'h00, 1'b1);
    rd(ADDR_POWER_CONTROL, 8'h00, 1'b1);
    rd(ADDR_PROGRAM_STATUS_WORD, 8'h00, 1'b1);
    rd(8'h80, 8'h00, 1'b0);
    $display("test reset done");
    // Pointer bytes and 24-bit increment
    wr(ADDR_POINTER_LOW_BYTE, 8'hff);
    wr(ADDR_POINTER_HIGH_BYTE, 8'hff);
    wr(ADDR_POINTER_PAGE_BYTE, 8'h12);
    rd(ADDR_POINTER_HIGH_BYTE, 8'hff, 1'b1);
    rd(ADDR_POINTER_PAGE_BYTE, 8'h12, 1'b1);
    strobe(0);
    `CHECK(data_pointer, 24'h130000)
    rd(ADDR_POINTER_LOW_BYTE, 8'h00, 1'b1);
    // On-chip data window
    wr(ADDR_CORE_CONFIGURATION, 8'h7f);
    rd(ADDR_CORE_CONFIGURATION, 8'h01, 1'b1);
    `CHECK(onchip_xdata_select, 1'b0)
    wr(ADDR_POINTER_PAGE_BYTE, 8'h00);
    wr(ADDR_POINTER_HIGH_BYTE, 8'h07);
    wr(ADDR_POINTER_LOW_BYTE, 8'hff);
    `CHECK(onchip_xdata_select, 1'b1)
    strobe(0);
    `CHECK(onchip_xdata_select, 1'b0)
    strobe(2);
    wr(ADDR_POINTER_HIGH_BYTE, 8'h01);
    `CHECK(onchip_xdata_select, 1'b1)
    wr(ADDR_CORE_CONFIGURATION, 8'h00);
    `CHECK(onchip_xdata_select, 1'b0)
    $display("test pointer done");
    // Plain stack
    wr(ADDR_STACK_POINTER_LOW, 8'h07);
    strobe(1);
    `CHECK(stack_top_address, 11'h008)
    wr(ADDR_STACK_POINTER_HIGH, 8'h03);
    rd(ADDR_STACK_POINTER_HIGH, 8'h00, 1'b0);
    wr(ADDR_STACK_POINTER_LOW, 8'hff);
    strobe(1);
    `CHECK(stack_top_address, 11'h000)
    rd(ADDR_STACK_POINTER_LOW, 8'h00, 1'b1);
    // Extended stack
    wr(ADDR_CORE_CONFIGURATION, 8'h80);
    `CHECK(extended_stack_enable, 1'b1)
    rd(ADDR_STACK_POINTER_HIGH, 8'h00, 1'b1);
    wr(ADDR_STACK_POINTER_LOW, 8'hff);
    strobe(1);
    `CHECK(stack_top_address, 11'h100)
    rd(ADDR_STACK_POINTER_HIGH, 8'h01, 1'b1);
    wr(ADDR_STACK_POINTER_HIGH, 8'h06);
    strobe(2);
    `CHECK(stack_top_address, 11'h5ff)
    wr(ADDR_CORE_CONFIGURATION, 8'h00);
    $display("test stack done");
    // Status word layout and bank select
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_PROGRAM_STATUS_WORD, 8'(b << 3));
      `CHECK(bank_select, 2'(b))
    end
    wr(ADDR_PROGRAM_STATUS_WORD, 8'hff);
    rd(ADDR_PROGRAM_STATUS_WORD, 8'hfe, 1'b1);
    @(posedge clock) status_flags_in <= 8'h55;
    strobe(3);
    @(posedge clock) acc_parity <= 1'b1;
    rd(ADDR_PROGRAM_STATUS_WORD, 8'h55, 1'b1);
    `CHECK(bank_select, 2'h2)
    `CHECK(program_status_word, 8'h55)
    $display("test status done");
    // Power control flags
    wr(ADDR_POWER_CONTROL, 8'h9d);
    `CHECK(baud_doubler, 1'b1)
    `CHECK(latch_strobe_enable, 1'b0)
    rd(ADDR_POWER_CONTROL, 8'h9c, 1'b1);
    wr(ADDR_POWER_CONTROL, 8'h00);
    `CHECK(baud_doubler, 1'b0)
    `CHECK(latch_strobe_enable, 1'b1)
    $display("test power flags done");
    // Power-down and wake sources
    wr(ADDR_POWER_CONTROL, 8'h02);
    `CHECK(powerdown_active, 1'b1)
    @(posedge clock) serial_irq <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    `CHECK(powerdown_active, 1'b1)
    wr(ADDR_POWER_CONTROL, 8'h42);
    wait_wake(4);
    @(posedge clock) serial_irq <= 1'b0;
    wr(ADDR_POWER_CONTROL, 8'h22);
    `CHECK(powerdown_active, 1'b1)
    @(posedge clock) external_interrupt_zero <= 1'b0;
    wait_wake(8);
    @(posedge clock);
    external_interrupt_zero <= 1'b1;
    ext_irq_edge_select <= 1'b1;
    repeat (4) @(posedge clock);
    wr(ADDR_POWER_CONTROL, 8'h22);
    `CHECK(powerdown_active, 1'b1)
    @(posedge clock) external_interrupt_zero <= 1'b0;
    wait_wake(8);
    $display("test power-down done");
    finish_test();
  end
endmodule
`default_nettype wire
